// [rtl/watchdog_interval_timer.sv]
// Contract
// (RULE1) in watchdog modes an overflow means runaway: raise nmi or reset per mode
// (RULE2) interval mode raises an interrupt repeatedly at the software chosen period
// (RULE3) clock select 000/010/100/110 divides by 16/64/256/1024; other codes prohibited
// (RULE4) software writes clock select only as a whole byte
// (RULE5) clock select register clears to zero on reset
// (RULE6) mode register takes bit and byte writes, clears to zero on reset
// (RULE7) run bit 0 keeps counter stopped; writing 1 clears counter then counts
// (RULE8) mode 00 stops operation; 01 interval mode with maskable interrupt per overflow
// (RULE9) mode 10 gives a non-maskable interrupt on overflow
// (RULE10) mode 11 starts a reset on overflow
// (RULE11) run bit once set ignores software writes of zero
// (RULE12) mode bits once set stay set until reset
// (RULE13) interval counting begins when the run bit is written to 1
// (RULE14) first overflow after restart may be up to 0.8 percent early
// (RULE15) software checks the watchdog flag is 0 before setting upper mode bit
// (RULE16) selecting a watchdog mode with flag already set gives an immediate nmi
// (RULE17) overflow after 128 count clocks, wrap to zero and keep counting
// (RULE18) every overflow in an active mode sets the flag until software clears it
`timescale 1ns/100ps
module watchdog_interval_timer
(
	// clock and control
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// special function register access
	input wire logic [15:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_bit_wr_in,
	input wire logic [2:0] sfr_bit_sel_in,
	input wire logic sfr_bit_val_in,
	input wire logic sfr_rd_in,
	output logic [7:0] sfr_rdata_out,
	// interrupt request flag
	input wire logic wdt_irq_flag_clr_in,
	output logic wdt_irq_flag_out,
	// events
	output logic intv_irq_out,
	output logic nmi_out,
	output logic wdt_reset_out,
	// status
	output logic running_out,
	output wdt_pkg::mode_e mode_out
);
	import wdt_pkg::*;

	typedef struct packed {
		logic [clksel_w-1:0] clksel;
		logic run;
		mode_e mode;
		logic [cnt_w-1:0] cnt;
		logic flag;
		logic intv_irq;
		logic nmi;
		logic wdt_rst;
		logic [7:0] rdata;
	} wdt_s;

	wdt_s state_r;
	wdt_s state_nxt;
	logic tick;

	// count clock divider, free running outside reset
	wdt_prescaler u_presc
	(
		.clock_in(clock_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.tap_in(state_r.clksel[2:1]),
		.tick_out(tick)
	);

	// register views as software reads them; unused bits read as zero
	logic [7:0] mode_view;
	logic [7:0] clksel_view;

	always_comb
	begin
		mode_view = '0;
		mode_view[run_pos] = state_r.run;
		mode_view[mode_hi_pos] = state_r.mode[1];
		mode_view[mode_lo_pos] = state_r.mode[0];
		clksel_view = '0;
		clksel_view[clksel_lsb +: clksel_w] = state_r.clksel;
	end

	logic mode_hit;
	logic csel_hit;
	logic [7:0] mode_wr;
	logic mode_we;
	logic run_kick;
	logic count_en;
	logic overflow;
	logic arm_nmi;

	// address decode and merge of a byte or bit write into the mode view
	always_comb
	begin
		mode_hit = (sfr_addr_in == wdt_mode_control_addr);
		csel_hit = (sfr_addr_in == wdt_clock_select_addr);
		mode_wr = mode_view;
		mode_we = 1'b0;
		run_kick = 1'b0;
		if (mode_hit && sfr_wr_in)
		begin
			mode_wr = sfr_wdata_in;
			mode_we = 1'b1;
			run_kick = sfr_wdata_in[run_pos];
		end
		else if (mode_hit && sfr_bit_wr_in) // RULE6
		begin
			mode_wr[sfr_bit_sel_in] = sfr_bit_val_in;
			mode_we = 1'b1;
			// a bit write to another bit must not restart the count
			run_kick = (sfr_bit_sel_in == 3'(run_pos)) && sfr_bit_val_in;
		end
	end

	// counting, overflow and the arming hazard
	always_comb
	begin
		count_en = state_r.run && (state_r.mode != mode_stop) && tick; // RULE8
		overflow = count_en && (state_r.cnt == cnt_last); // RULE17
		// flag already pending when a watchdog mode is first chosen
		arm_nmi = mode_we && !state_r.mode[1] && mode_wr[mode_hi_pos] && state_r.flag; // RULE16
	end

	logic intv_hit;
	logic nmi_hit;
	logic rst_hit;

	// one event kind per mode; overflow is already gated off in stop mode
	always_comb
	begin
		intv_hit = 1'b0;
		nmi_hit = 1'b0;
		rst_hit = 1'b0;
		case (state_r.mode)
			mode_interval: intv_hit = overflow; // RULE2 RULE8
			mode_wdt_nmi: nmi_hit = overflow; // RULE1 RULE9
			mode_wdt_reset: rst_hit = overflow; // RULE1 RULE10
			default: intv_hit = 1'b0;
		endcase
	end

	always_comb
	begin
		state_nxt = state_r;
		// clock select takes byte writes only; bit writes are dropped
		if (csel_hit && sfr_wr_in)
		begin
			state_nxt.clksel = sfr_wdata_in[clksel_lsb +: clksel_w]; // RULE4
		end
		// run and mode bits are only or-ed in, so runaway code cannot disarm
		if (mode_we)
		begin
			state_nxt.run = state_r.run | mode_wr[run_pos]; // RULE11
			state_nxt.mode = mode_e'(state_r.mode | {mode_wr[mode_hi_pos],
				mode_wr[mode_lo_pos]}); // RULE12
		end
		// the kick clears only the counter; the prescaler keeps its phase
		if (run_kick)
		begin
			state_nxt.cnt = '0; // RULE7 RULE13
		end
		else if (count_en)
		begin
			state_nxt.cnt = state_r.cnt + 7'h01; // RULE17
		end
		state_nxt.intv_irq = intv_hit;
		state_nxt.nmi = nmi_hit || arm_nmi;
		state_nxt.wdt_rst = rst_hit;
		// set beats a clear in the same cycle
		if (overflow)
		begin
			state_nxt.flag = 1'b1; // RULE18
		end
		else if (wdt_irq_flag_clr_in)
		begin
			state_nxt.flag = 1'b0;
		end
		// read data stands one cycle; unmapped addresses read as zero
		state_nxt.rdata = 8'h00;
		if (sfr_rd_in)
		begin
			if (mode_hit)
				state_nxt.rdata = mode_view;
			else if (csel_hit)
				state_nxt.rdata = clksel_view;
		end
	end

	// reset acts even while the clock enable is low
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			state_r <= '0;
			state_r.clksel <= wdt_clock_select_rst[clksel_w-1:0]; // RULE5
			state_r.run <= wdt_mode_control_rst[run_pos]; // RULE6
			state_r.mode <= mode_stop;
		end
		else if (ce_in)
			state_r <= state_nxt;
	end

	assign sfr_rdata_out = state_r.rdata;
	assign wdt_irq_flag_out = state_r.flag;
	assign intv_irq_out = state_r.intv_irq;
	assign nmi_out = state_r.nmi;
	assign wdt_reset_out = state_r.wdt_rst;
	assign running_out = state_r.run;
	assign mode_out = state_r.mode;
endmodule // watchdog_interval_timer

// [rtl/wdt_pkg.sv]
package wdt_pkg;
	localparam logic [15:0] wdt_clock_select_addr = 16'hff42;
	localparam logic [15:0] wdt_mode_control_addr = 16'hff48;
	localparam logic [7:0] wdt_clock_select_rst = 8'h00;
	localparam logic [7:0] wdt_mode_control_rst = 8'h00;
	localparam int clksel_lsb = 0;
	localparam int clksel_w = 3;
	localparam int run_pos = 7;
	localparam int mode_hi_pos = 4;
	localparam int mode_lo_pos = 3;
	localparam int presc_w = 10;
	localparam int div_count = 4;
	// log2 of prescaler division for clksel codes 000, 010, 100, 110
	localparam int div_log2 [div_count] = '{4, 6, 8, 10};
	localparam int cnt_w = 7;
	localparam logic [6:0] cnt_last = 7'h7f;
	typedef enum logic [1:0] {
		mode_stop = 2'b00,
		mode_interval = 2'b01,
		mode_wdt_nmi = 2'b10,
		mode_wdt_reset = 2'b11
	} mode_e;
endpackage

// [rtl/wdt_prescaler.sv]
`timescale 1ns/100ps
module wdt_prescaler
(
	// clock and control
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// tap select, clksel bits 2:1
	input wire logic [1:0] tap_in,
	// count clock tick
	output logic tick_out
);
	import wdt_pkg::*;

	typedef struct packed {
		logic [presc_w-1:0] presc;
		logic tick;
	} presc_s;

	presc_s state_r;
	presc_s state_nxt;
	logic [div_count-1:0] tap_hit;

	// the divider is never cleared by a restart, so the first count period may be short
	genvar g;
	generate
		for (g = 0; g < div_count; g++)
		begin : g_tap
			assign tap_hit[g] = &state_r.presc[div_log2[g]-1:0];
		end
	endgenerate

	always_comb
	begin
		state_nxt = state_r;
		state_nxt.presc = state_r.presc + 10'h001;
		state_nxt.tick = tap_hit[tap_in]; // RULE3 RULE14
	end

	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			state_r <= '0;
		else if (ce_in)
			state_r <= state_nxt;
	end

	assign tick_out = state_r.tick;
endmodule // wdt_prescaler

// [testbench/wdt_checker_sva.sv]
`timescale 1ns/100ps
module wdt_checker
(
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// watched outputs
	input wire logic wdt_irq_flag_out,
	input wire logic intv_irq_out,
	input wire logic nmi_out,
	input wire logic wdt_reset_out,
	input wire logic running_out,
	input wire wdt_pkg::mode_e mode_out
);
	import wdt_pkg::*;
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	wire ev = intv_irq_out || nmi_out || wdt_reset_out;
	sequence one_pulse;
		ev ##1 !ev;
	endsequence
	run_hold_a: assert property (running_out |=> running_out) else $error("run dropped");
	mode_hold_a: assert property (!$past(rst_in) |->
		(mode_out & $past(mode_out)) == $past(mode_out)) else $error("mode bit dropped");
	intv_mode_a: assert property (intv_irq_out |-> $past(mode_out) == mode_interval)
		else $error("intv in bad mode");
	reset_mode_a: assert property (wdt_reset_out |-> $past(mode_out) == mode_wdt_reset)
		else $error("reset in bad mode");
	nmi_mode_a: assert property (nmi_out |-> mode_out[1]) else $error("nmi in bad mode");
	flag_set_a: assert property (ev |-> wdt_irq_flag_out) else $error("flag not set");
	run_event_a: assert property (intv_irq_out || wdt_reset_out |-> running_out)
		else $error("event while stopped");
	one_pulse_a: assert property (ev |-> one_pulse) else $error("event too long");
endmodule // wdt_checker
bind watchdog_interval_timer wdt_checker sva_i (.clock_in, .rst_in, .wdt_irq_flag_out,
	.intv_irq_out, .nmi_out, .wdt_reset_out, .running_out, .mode_out);

// [testbench/watchdog_interval_timer_bench.sv]
`timescale 1ns/100ps
module watchdog_interval_timer_bench;
	import wdt_pkg::*;
	localparam logic [15:0] csel = wdt_clock_select_addr;
	localparam logic [15:0] mreg = wdt_mode_control_addr;
	logic clock_in = 0, rst_in = 1, ce_in = 1, sfr_wr_in = 0, sfr_bit_wr_in = 0, sfr_rd_in = 0;
	logic sfr_bit_val_in = 0, wdt_irq_flag_clr_in = 0, wdt_irq_flag_out, intv_irq_out, nmi_out;
	logic wdt_reset_out, running_out;
	logic [15:0] sfr_addr_in = '0;
	logic [7:0] sfr_wdata_in = '0, sfr_rdata_out;
	logic [2:0] sfr_bit_sel_in = '0;
	mode_e mode_out;
	int err_count = 0, checks = 0, cyc = 0, n, p;
	watchdog_interval_timer DUT (.*);
	initial forever #4 clock_in = ~clock_in;
	initial
	begin
		while (cyc < 40000)
			@(posedge clock_in) cyc++;
		err_count++;
		wrap_up();
	end
	task automatic step();
		@(posedge clock_in);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// k: 0 byte write, 1 bit write (d[2:0] bit, d[7] value), 2 read against d
	task automatic bus(input int k, input logic [15:0] a, input logic [7:0] d);
		step();
		sfr_addr_in = a;
		sfr_wdata_in = d;
		sfr_bit_sel_in = d[2:0];
		sfr_bit_val_in = d[7];
		{sfr_rd_in, sfr_bit_wr_in, sfr_wr_in} = 3'(1 << k);
		step();
		{sfr_rd_in, sfr_bit_wr_in, sfr_wr_in} = 3'h0;
		if (k == 2)
			chk(sfr_rdata_out, d);
	endtask
	// always steps once, so a pulse still showing is not counted twice
	task automatic wait_ev(ref logic s);
		n = 0;
		while (s !== 1'b1 && n < 9000 || n == 0)
		begin
			step();
			n++;
		end
	endtask
	task automatic wrap_up();
		if (err_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (3) step();
		rst_in = 0;
		bus(2, csel, wdt_clock_select_rst);
		bus(2, mreg, wdt_mode_control_rst);
		bus(0, csel, 8'hff);
		bus(2, csel, 8'h07);
		bus(1, mreg, 8'h83);
		bus(2, mreg, 8'h08);
		for (int k = 0; k < 2; k++)
		begin
			p = 2048 << (2 * k);
			bus(0, csel, 8'(2 * k));
			bus(0, mreg, 8'h88);
			wait_ev(intv_irq_out);
			chk(n > p - p / 128 - 2 && n <= p + 1, 1);
			wait_ev(intv_irq_out);
			chk(n, p);
		end
		bus(1, mreg, 8'h84);
		chk(nmi_out, 1);
		bus(0, mreg, 8'h00);
		bus(2, mreg, 8'h98);
		wait_ev(wdt_reset_out);
		chk(wdt_reset_out, 1);
		wdt_irq_flag_clr_in = 1;
		step();
		wdt_irq_flag_clr_in = 0;
		chk(wdt_irq_flag_out, 0);
		rst_in = 1;
		repeat (3) step();
		rst_in = 0;
		chk(running_out, 0);
		bus(2, csel, 8'h00);
		bus(0, mreg, 8'h90);
		chk(running_out, 1);
		chk(mode_out, mode_wdt_nmi);
		ce_in = 0;
		repeat (100) step();
		ce_in = 1;
		p = 2048;
		wait_ev(nmi_out);
		chk(n > p - p / 128 - 2 && n <= p + 1, 1);
		chk(nmi_out & wdt_irq_flag_out, 1);
		wrap_up();
	end
endmodule // watchdog_interval_timer_bench
